// >>> fci_pkg.sv
// Constants and types shared by the flash card host controller.
// How it works
// - Strobes return high between reads.
// - Host checks both status byte lanes.
// - Supply error needs clear before programming.
// - Erase is setup then confirm in block.
// - Host checks erase fail after erase.
// - Word write is setup then address/data.
package fci_pkg;
	localparam int T_CLK_NS = 50;
	localparam int T_PULSE_NS = 150;
	localparam int T_REC_NS = 100;
	localparam int T_SETTLE_NS = 200;
	localparam int PULSE_CYC = (T_PULSE_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int REC_CYC = (T_REC_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int SETTLE_CYC = (T_SETTLE_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	// Command words: the same byte on both lanes.
	localparam logic [15:0] CMD_READ_ARRAY = 16'hFFFF;
	localparam logic [15:0] CMD_READ_ID = 16'h9090;
	localparam logic [15:0] CMD_READ_STATUS = 16'h7070;
	localparam logic [15:0] CMD_CLEAR_STATUS = 16'h5050;
	localparam logic [15:0] CMD_ERASE_SETUP = 16'h2020;
	localparam logic [15:0] CMD_CONFIRM = 16'hD0D0;
	localparam logic [15:0] CMD_WRITE_SETUP = 16'h4040;
	// Card status bit positions within one byte lane.
	localparam int SR_MACHINE_READY = 7;
	localparam int SR_ERASE_FAIL = 5;
	localparam int SR_PROGRAM_FAIL = 4;
	localparam int SR_PROGRAM_SUPPLY = 3;
	localparam int SR_LOCK_VIOLATION = 1;
	// Software register offsets.
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	// Status register fields.
	localparam int ST_BUSY = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_ERASE_FAIL = 2;
	localparam int ST_PROGRAM_FAIL = 3;
	localparam int ST_LOCK_VIOLATION = 4;
	localparam int ST_SUPPLY_ERROR = 5;
	localparam int ST_MACHINE_READY = 6;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	typedef enum logic [2:0] {
		OP_READ_ARRAY = 3'h0,
		OP_READ_ID = 3'h1,
		OP_READ_STATUS = 3'h2,
		OP_CLEAR_STATUS = 3'h3,
		OP_ERASE = 3'h4,
		OP_WRITE = 3'h5,
		OP_READ = 3'h6,
		OP_NONE = 3'h7
	} fci_op_type;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_CYC1 = 3'h1,
		S_CYC2 = 3'h3,
		S_SETTLE = 3'h2,
		S_WAIT = 3'h6,
		S_STAT = 3'h7,
		S_EVAL = 3'h5
	} fci_state_type;
	typedef enum logic [1:0] {
		B_IDLE = 2'h0,
		B_SETUP = 2'h1,
		B_PULSE = 2'h3,
		B_REC = 2'h2
	} fci_bus_state_type;
endpackage

// >>> fci_bus_cycle.sv
// One asynchronous card bus cycle, read or write, with strobe timing.
`timescale 1ns/10ps
module fci_bus_cycle
	import fci_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_write,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic [DATA_W-1:0] i_pin_data,
	output logic o_done,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic o_data_oe,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_data
);
	fci_bus_state_type state_q;
	logic [2:0] cnt_q;
	logic write_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= B_IDLE;
			cnt_q <= 3'h0;
			write_q <= 1'b0;
			o_done <= 1'b0;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_data_oe <= 1'b0;
			o_addr <= '0;
			o_data <= '0;
			o_rdata <= '0;
		end else begin
			o_done <= 1'b0;
			unique case (state_q)
				B_IDLE: begin
					if (i_start) begin
						write_q <= i_write;
						o_addr <= i_addr;
						o_data <= i_wdata;
						o_data_oe <= i_write;
						o_ce_n <= 1'b0;
						state_q <= B_SETUP;
					end
				end
				B_SETUP: begin
					o_we_n <= !write_q;
					o_oe_n <= write_q;
					cnt_q <= 3'(PULSE_CYC - 1);
					state_q <= B_PULSE;
				end
				B_PULSE: begin
					if (cnt_q == 3'h0) begin
						// Write data latches on this rising edge of we.
						o_we_n <= 1'b1;
						o_oe_n <= 1'b1;
						o_ce_n <= 1'b1;
						cnt_q <= 3'(REC_CYC - 1);
						state_q <= B_REC;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				B_REC: begin
					if (cnt_q == 3'h0) begin
						o_data_oe <= 1'b0;
						o_done <= 1'b1;
						// Synchronised pins lag two cycles: this is the pulse.
						o_rdata <= i_pin_data;
						state_q <= B_IDLE;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
			endcase
		end
	end

	property p_strobe_recovery;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_ce_n) |=> o_ce_n && o_oe_n;
	endproperty
	a_strobe_recovery: assert property (p_strobe_recovery)
		else $error("chip enable fell again without recovery");

	property p_read_gap;
		@(posedge i_clk) disable iff (!i_rst_n)
		$fell(o_oe_n) |-> $past(o_oe_n, 2) && $past(o_ce_n, 2);
	endproperty
	a_read_gap: assert property (p_read_gap)
		else $error("output enable fell without prior release");
endmodule

// >>> fci_host.sv
// Host controller that sequences commands to a 16-bit flash card.
`timescale 1ns/10ps
module fci_host
	import fci_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_write,
	input wire logic i_reg_read,
	output logic [31:0] o_reg_rdata,
	input wire logic [DATA_W-1:0] i_card_data,
	input wire logic i_card_ready_busy_n,
	output logic o_card_ce_n,
	output logic o_card_oe_n,
	output logic o_card_we_n,
	output logic o_card_data_oe,
	output logic [ADDR_W-1:0] o_card_addr,
	output logic [DATA_W-1:0] o_card_data,
	output logic o_busy
);
	logic rst_meta_q;
	logic rst_n_q;
	logic [DATA_W-1:0] data_meta_q;
	logic [DATA_W-1:0] data_sync_q;
	logic rb_meta_q;
	logic rb_sync_q;
	fci_state_type state_q;
	fci_op_type op_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] result_q;
	logic bus_start_q;
	logic bus_write_q;
	logic [DATA_W-1:0] bus_wdata_q;
	logic bus_done;
	logic [DATA_W-1:0] bus_rdata;
	logic [2:0] settle_q;
	logic refused_q;
	logic erase_fail_q;
	logic program_fail_q;
	logic lock_viol_q;
	logic supply_err_q;
	logic machine_ready_q;
	logic cmd_hit;
	fci_op_type cmd_op;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			data_meta_q <= '0;
			data_sync_q <= '0;
			rb_meta_q <= 1'b1;
			rb_sync_q <= 1'b1;
		end else begin
			data_meta_q <= i_card_data;
			data_sync_q <= data_meta_q;
			rb_meta_q <= i_card_ready_busy_n;
			rb_sync_q <= rb_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign cmd_hit = i_reg_write && (i_reg_addr == REG_CMD);
	assign cmd_op = fci_op_type'(i_reg_wdata[2:0]);

	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			addr_q <= '0;
			wdata_q <= '0;
		end else if (state_q == S_IDLE && i_reg_write) begin
			if (i_reg_addr == REG_ADDR) begin
				addr_q <= i_reg_wdata[ADDR_W-1:0];
			end
			if (i_reg_addr == REG_WDATA) begin
				wdata_q <= i_reg_wdata[DATA_W-1:0];
			end
		end
	end
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_reg_rdata <= RDATA_RESET;
		end else begin
			o_reg_rdata <= RDATA_RESET;
			if (i_reg_read) begin
				unique case (i_reg_addr)
					REG_ADDR: o_reg_rdata <= 32'(addr_q);
					REG_WDATA: o_reg_rdata <= 32'(wdata_q);
					REG_RDATA: o_reg_rdata <= 32'(result_q);
					REG_STATUS: begin
						o_reg_rdata[ST_BUSY] <= o_busy;
						o_reg_rdata[ST_REFUSED] <= refused_q;
						o_reg_rdata[ST_ERASE_FAIL] <= erase_fail_q;
						o_reg_rdata[ST_PROGRAM_FAIL] <= program_fail_q;
						o_reg_rdata[ST_LOCK_VIOLATION] <= lock_viol_q;
						o_reg_rdata[ST_SUPPLY_ERROR] <= supply_err_q;
						o_reg_rdata[ST_MACHINE_READY] <= machine_ready_q;
					end
					default: o_reg_rdata <= RDATA_RESET;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: issues the command cycles and polls for completion.
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= S_IDLE;
			op_q <= OP_NONE;
			bus_start_q <= 1'b0;
			bus_write_q <= 1'b0;
			bus_wdata_q <= '0;
			settle_q <= 3'h0;
			result_q <= '0;
			o_busy <= 1'b0;
		end else begin
			bus_start_q <= 1'b0;
			unique case (state_q)
				S_IDLE: begin
					if (cmd_hit && cmd_op != OP_NONE && !((cmd_op == OP_ERASE ||
							cmd_op == OP_WRITE) && supply_err_q)) begin
						op_q <= cmd_op;
						o_busy <= 1'b1;
						bus_start_q <= 1'b1;
						bus_write_q <= (cmd_op != OP_READ);
						state_q <= S_CYC1;
						unique case (cmd_op)
							OP_READ_ARRAY: bus_wdata_q <= CMD_READ_ARRAY;
							OP_READ_ID: bus_wdata_q <= CMD_READ_ID;
							OP_READ_STATUS: bus_wdata_q <= CMD_READ_STATUS;
							OP_CLEAR_STATUS: bus_wdata_q <= CMD_CLEAR_STATUS;
							OP_ERASE: bus_wdata_q <= CMD_ERASE_SETUP;
							OP_WRITE: bus_wdata_q <= CMD_WRITE_SETUP;
							default: bus_wdata_q <= '0;
						endcase
					end
				end
				S_CYC1: begin
					if (bus_done) begin
						if (op_q == OP_CLEAR_STATUS || op_q == OP_READ) begin
							result_q <= bus_rdata;
							o_busy <= 1'b0;
							state_q <= S_IDLE;
						end else begin
							bus_start_q <= 1'b1;
							bus_write_q <= (op_q == OP_ERASE || op_q == OP_WRITE);
							bus_wdata_q <= (op_q == OP_ERASE) ? CMD_CONFIRM
								: wdata_q;
							state_q <= S_CYC2;
						end
					end
				end
				S_CYC2: begin
					if (bus_done) begin
						if (op_q == OP_ERASE || op_q == OP_WRITE) begin
							settle_q <= 3'(SETTLE_CYC - 1);
							state_q <= S_SETTLE;
						end else begin
							result_q <= bus_rdata;
							o_busy <= 1'b0;
							state_q <= S_IDLE;
						end
					end
				end
				S_SETTLE: begin
					if (settle_q == 3'h0) begin
						state_q <= S_WAIT;
					end else begin
						settle_q <= settle_q - 3'h1;
					end
				end
				S_WAIT: begin
					// The card stays in status mode, so a bare read suffices.
					if (rb_sync_q) begin
						bus_start_q <= 1'b1;
						bus_write_q <= 1'b0;
						state_q <= S_STAT;
					end
				end
				S_STAT: begin
					if (bus_done) begin
						result_q <= bus_rdata;
						state_q <= S_EVAL;
					end
				end
				S_EVAL: begin
					o_busy <= 1'b0;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Error flags: a set in the evaluation cycle wins over a clear.
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			erase_fail_q <= 1'b0;
			program_fail_q <= 1'b0;
			lock_viol_q <= 1'b0;
			supply_err_q <= 1'b0;
			machine_ready_q <= 1'b0;
		end else if (state_q == S_EVAL) begin
			erase_fail_q <= erase_fail_q | result_q[SR_ERASE_FAIL]
				| result_q[SR_ERASE_FAIL+8];
			program_fail_q <= program_fail_q | result_q[SR_PROGRAM_FAIL]
				| result_q[SR_PROGRAM_FAIL+8];
			lock_viol_q <= lock_viol_q | result_q[SR_LOCK_VIOLATION]
				| result_q[SR_LOCK_VIOLATION+8];
			supply_err_q <= supply_err_q | result_q[SR_PROGRAM_SUPPLY]
				| result_q[SR_PROGRAM_SUPPLY+8];
			machine_ready_q <= result_q[SR_MACHINE_READY]
				& result_q[SR_MACHINE_READY+8];
		end else if (state_q == S_CYC1 && bus_done &&
				op_q == OP_CLEAR_STATUS) begin
			erase_fail_q <= 1'b0;
			program_fail_q <= 1'b0;
			lock_viol_q <= 1'b0;
			supply_err_q <= 1'b0;
		end
	end
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			refused_q <= 1'b0;
		end else if (cmd_hit) begin
			refused_q <= (state_q != S_IDLE) || cmd_op == OP_NONE ||
				((cmd_op == OP_ERASE || cmd_op == OP_WRITE) && supply_err_q);
		end
	end
	fci_bus_cycle u_bus (
		.i_clk(i_clk),
		.i_rst_n(rst_n_q),
		.i_start(bus_start_q),
		.i_write(bus_write_q),
		.i_addr(addr_q),
		.i_wdata(bus_wdata_q),
		.i_pin_data(data_sync_q),
		.o_done(bus_done),
		.o_rdata(bus_rdata),
		.o_ce_n(o_card_ce_n),
		.o_oe_n(o_card_oe_n),
		.o_we_n(o_card_we_n),
		.o_data_oe(o_card_data_oe),
		.o_addr(o_card_addr),
		.o_data(o_card_data)
	);
	////////////////////////////////////////////////////////////////////////
	property p_supply_block;
		@(posedge i_clk) disable iff (!rst_n_q)
		(state_q == S_IDLE && cmd_hit && supply_err_q &&
			(cmd_op == OP_ERASE || cmd_op == OP_WRITE))
			|=> state_q == S_IDLE && refused_q;
	endproperty
	a_supply_block: assert property (p_supply_block)
		else $error("write or erase started with supply error set");
	property p_both_lanes;
		@(posedge i_clk) disable iff (!rst_n_q)
		(state_q == S_EVAL && (result_q[SR_PROGRAM_FAIL+8] ||
			result_q[SR_PROGRAM_FAIL])) |=> program_fail_q;
	endproperty
	a_both_lanes: assert property (p_both_lanes)
		else $error("program fail on one lane was missed");
	property p_erase_fail;
		@(posedge i_clk) disable iff (!rst_n_q)
		(state_q == S_EVAL && op_q == OP_ERASE && result_q[SR_ERASE_FAIL+8])
			|=> erase_fail_q ##1 erase_fail_q;
	endproperty
	a_erase_fail: assert property (p_erase_fail)
		else $error("erase fail not recorded after erase");
	property p_erase_pair;
		@(posedge i_clk) disable iff (!rst_n_q)
		(state_q == S_CYC1 && bus_done && op_q == OP_ERASE)
			|=> bus_start_q && bus_write_q && bus_wdata_q == CMD_CONFIRM
			&& $stable(addr_q);
	endproperty
	a_erase_pair: assert property (p_erase_pair)
		else $error("erase confirm not issued after setup");
	property p_write_pair;
		@(posedge i_clk) disable iff (!rst_n_q)
		(state_q == S_IDLE && cmd_hit && cmd_op == OP_WRITE && !supply_err_q)
			|=> bus_wdata_q == CMD_WRITE_SETUP ##[1:20] (bus_start_q &&
			bus_wdata_q == wdata_q);
	endproperty
	a_write_pair: assert property (p_write_pair)
		else $error("word write not setup then data");
	property p_same_lanes;
		@(posedge i_clk) disable iff (!rst_n_q)
		(bus_start_q && state_q == S_CYC1)
			|-> bus_wdata_q[15:8] == bus_wdata_q[7:0];
	endproperty
	a_same_lanes: assert property (p_same_lanes)
		else $error("command byte lanes differ");
endmodule

// >>> fci_card_model.sv
// Behavioural 16-bit flash card made of two byte lanes.
`timescale 1ns/10ps
module fci_card_model
	import fci_pkg::*;
#(
	parameter logic [7:0] MFR_CODE = 8'h3C, // Arbitrary value.
	parameter logic [7:0] DEV_CODE = 8'h5E, // Arbitrary value.
	parameter logic [6:0] LOCK_BLK = 7'h03,
	// A word written at this address fails its verify.
	parameter logic [15:0] BAD_WORD = 16'h0BAD,
	parameter int BUSY_NS = 400
)
(
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_data,
	input wire logic i_supply_fault,
	input wire logic i_write_protect,
	output logic [DATA_W-1:0] o_data,
	output logic o_ready_busy_n = 1'b1,
	output logic [DATA_W-1:0] o_last_cmd = 16'h0000
);
	typedef enum logic [1:0] {M_ARRAY, M_ID, M_STAT} fci_mode_type;
	fci_mode_type mode = M_ARRAY;
	logic [7:0] sr = 8'h80;
	logic [7:0] sr_lat = 8'h80;
	logic [1:0] pend = 2'h0;
	logic [15:0] val;
	logic [15:0] last = 16'h0000;
	logic lk;
	wire en;
	// The lanes hold data briefly after the strobes rise, then drive the complement of the last word read.
	assign #(0,10) en = ~i_ce_n & ~i_oe_n;
	assign o_data = en ? val : ~last;
	always @(negedge en) last = val;
	assign lk = (i_addr[22:16] == LOCK_BLK);
	////////////////////////////////////////////////////////////////////
	always @(posedge i_we_n) begin
		if (!i_write_protect) o_last_cmd = i_data;
		if (pend != 2'h0 && !i_write_protect) begin
			mode = M_STAT;
			if (pend == 2'h1 && i_data != CMD_CONFIRM) begin
				sr[5:4] = 2'h3;
			end else if (lk) begin
				sr = sr | (pend == 2'h1 ? 8'h22 : 8'h12);
			end else begin
				sr[7] = 1'b0;
				if (pend == 2'h2 && i_addr[15:0] == BAD_WORD) begin
					sr[4] = 1'b1;
				end
				o_ready_busy_n = 1'b0;
			end
			pend = 2'h0;
		end else if (i_data[15:8] == i_data[7:0] && !i_write_protect) begin
			case (i_data)
				CMD_READ_ARRAY: if (o_ready_busy_n) mode = M_ARRAY;
				CMD_READ_ID: mode = M_ID;
				CMD_READ_STATUS: mode = M_STAT;
				CMD_CLEAR_STATUS: sr = sr & 8'hC5;
				CMD_ERASE_SETUP: pend = 2'h1;
				CMD_WRITE_SETUP, 16'h1010: pend = 2'h2;
				default: ;
			endcase
		end
	end
	always @(negedge o_ready_busy_n) begin
		#BUSY_NS;
		sr[7] = 1'b1;
		o_ready_busy_n = 1'b1;
	end
	always @(posedge i_supply_fault) sr[3] = 1'b1;
	// Status is frozen by whichever strobe falls first.
	always @(negedge i_oe_n or negedge i_ce_n) begin
		if (i_ce_n || i_oe_n) sr_lat = sr;
	end
	always_comb begin
		case (mode)
			M_ARRAY: val = i_addr[15:0] ^ 16'h5A5A;
			M_ID: begin
				case (i_addr[15:0])
					16'h0000: val = {MFR_CODE, MFR_CODE};
					16'h0001: val = {DEV_CODE, DEV_CODE};
					default: val = {7'h00, lk, 7'h00, lk};
				endcase
			end
			default: val = {sr_lat, sr_lat};
		endcase
	end
endmodule

// >>> fci_host_tb.sv
// Self-checking testbench of the flash card host controller.
`timescale 1ns/10ps
module fci_host_tb;
	import fci_pkg::*;
	localparam logic [6:0] LOCK_BLK = 7'h03;
	localparam logic [7:0] MFR_CODE = 8'h3C; // Arbitrary value.
	localparam logic [7:0] DEV_CODE = 8'h5E; // Arbitrary value.
	localparam logic [31:0] ST_LOCK = 32'h1 << ST_LOCK_VIOLATION;
	localparam logic [31:0] ST_PRG = 32'h1 << ST_PROGRAM_FAIL;
	localparam logic [31:0] ST_ERS = 32'h1 << ST_ERASE_FAIL;
	localparam logic [31:0] ST_SUP = 32'h1 << ST_SUPPLY_ERROR;
	localparam logic [31:0] ST_REF = 32'h1 << ST_REFUSED;
	localparam logic [31:0] ST_RDY = 32'h1 << ST_MACHINE_READY;
	logic i_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic [15:0] card_rd;
	logic [15:0] card_wd;
	logic [15:0] last_cmd;
	logic [22:0] card_addr;
	logic rbn, ce_n, oe_n, we_n, data_oe, busy;
	logic supply_fault = 1'b0;
	logic write_protect = 1'b0;
	logic saw_busy = 1'b0;
	logic [31:0] v;
	int fail_count = 0;
	int tests_run = 0;
	always #25 i_clk = ~i_clk;
	always @(negedge rbn) saw_busy = 1'b1;
	fci_host dut_u (.i_clk(i_clk), .i_resetn(resetn), .i_reg_addr(reg_addr),
		.i_reg_wdata(reg_wdata), .i_reg_write(reg_write),
		.i_reg_read(reg_read), .o_reg_rdata(reg_rdata),
		.i_card_data(card_rd), .i_card_ready_busy_n(rbn),
		.o_card_ce_n(ce_n), .o_card_oe_n(oe_n), .o_card_we_n(we_n),
		.o_card_data_oe(data_oe), .o_card_addr(card_addr),
		.o_card_data(card_wd), .o_busy(busy));
	fci_card_model #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE),
		.LOCK_BLK(LOCK_BLK)) card_u (.i_ce_n(ce_n), .i_oe_n(oe_n),
		.i_we_n(we_n), .i_addr(card_addr), .i_data(card_wd),
		.i_supply_fault(supply_fault), .o_data(card_rd),
		.i_write_protect(write_protect),
		.o_ready_busy_n(rbn), .o_last_cmd(last_cmd));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge i_clk);
		reg_write <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge i_clk);
		reg_read <= 1'b0;
		@(negedge i_clk);
		v = reg_rdata;
		@(posedge i_clk);
	endtask
	task automatic op(input fci_op_type o, input logic [22:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		wr(REG_ADDR, {9'h0, a});
		wr(REG_WDATA, {16'h0, d});
		wr(REG_CMD, {29'h0, o});
		@(negedge i_clk);
		while (busy !== 1'b0 && n < 400) begin
			@(negedge i_clk);
			n++;
		end
		@(posedge i_clk);
		if (n >= 400) chk(32'h0, 32'h1);
	endtask
	task automatic chk_word(input logic [15:0] exp);
		rd(REG_RDATA);
		chk({16'h0, v[15:0]}, {16'h0, exp});
	endtask
	task automatic chk_stat(input logic [31:0] mask, input logic [31:0] exp);
		rd(REG_STATUS);
		chk(v & mask, exp);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk({28'h0, busy, ce_n, we_n, data_oe}, 32'h6);
		op(OP_READ, 23'h5, 16'h0);
		chk_word(16'h5A5F);
		$display("test reset done");
	endtask
	task automatic t_status;
		op(OP_READ_STATUS, 23'h0, 16'h0);
		chk({16'h0, last_cmd}, {16'h0, CMD_READ_STATUS});
		chk_word(16'h8080);
		op(OP_READ, 23'h9, 16'h0);
		chk_word(16'h8080);
		$display("test status done");
	endtask
	task automatic t_id;
		op(OP_READ_ID, 23'h0, 16'h0);
		chk_word({MFR_CODE, MFR_CODE});
		op(OP_READ, 23'h1, 16'h0);
		chk_word({DEV_CODE, DEV_CODE});
		op(OP_READ, {LOCK_BLK, 16'h0002}, 16'h0);
		chk_word(16'h0101);
		op(OP_READ, {7'h04, 16'h0002}, 16'h0);
		chk_word(16'h0000);
		$display("test id done");
	endtask
	task automatic t_flags;
		op(OP_WRITE, {LOCK_BLK, 16'h0010}, 16'h1234);
		chk_stat(32'h7E, ST_LOCK | ST_PRG | ST_RDY);
		op(OP_ERASE, {7'h05, 16'h0000}, 16'h0);
		chk({16'h0, last_cmd}, {16'h0, CMD_CONFIRM});
		chk({31'h0, saw_busy}, 32'h1);
		chk_stat(32'h7E, ST_LOCK | ST_PRG | ST_RDY);
		op(OP_READ, 23'h0, 16'h0);
		chk_word(16'h9292);
		op(OP_CLEAR_STATUS, 23'h0, 16'h0);
		op(OP_READ, 23'h0, 16'h0);
		chk_word(16'h8080);
		op(OP_ERASE, {LOCK_BLK, 16'h0000}, 16'h0);
		chk_stat(32'h3E, ST_LOCK | ST_ERS);
		op(OP_CLEAR_STATUS, 23'h0, 16'h0);
		$display("test flags done");
	endtask
	task automatic t_supply;
		supply_fault <= 1'b1;
		op(OP_WRITE, {7'h05, 16'h0020}, 16'h00FF);
		chk_stat(ST_SUP, ST_SUP);
		op(OP_ERASE, {7'h05, 16'h0000}, 16'h0);
		chk({16'h0, last_cmd}, 32'h00FF);
		chk_stat(ST_REF, ST_REF);
		supply_fault <= 1'b0;
		op(OP_CLEAR_STATUS, 23'h0, 16'h0);
		op(OP_ERASE, {7'h05, 16'h0000}, 16'h0);
		chk_stat(32'h3E, 32'h0);
		op(OP_WRITE, {7'h05, 16'h0BAD}, 16'h0000);
		chk_stat(32'h3E, ST_PRG);
		op(OP_CLEAR_STATUS, 23'h0, 16'h0);
		$display("test supply done");
	endtask
	task automatic t_array;
		op(OP_READ_ARRAY, 23'h7, 16'h0);
		chk_word(16'h5A5D);
		op(OP_READ, 23'h8, 16'h0);
		chk_word(16'h5A52);
		write_protect <= 1'b1;
		op(OP_READ_ID, 23'h0, 16'h0);
		chk_word(16'h5A5A);
		chk({16'h0, last_cmd}, {16'h0, CMD_READ_ARRAY});
		write_protect <= 1'b0;
		$display("test array done");
	endtask
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge i_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge i_clk);
		t_reset();
		t_status();
		t_id();
		t_flags();
		t_supply();
		t_array();
		stop_test();
	end
	initial begin
		#2000000;
		fail_count++;
		stop_test();
	end
endmodule
